/* File: nsp_consts.svh */
/*
 * Constants of the nibble sample port: timing, control-frame layout,
 * field positions, saturation limits and reset values.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef NSP_CONSTS_SVH
`define NSP_CONSTS_SVH

// clock rates, in kHz
`define NSP_REF_FREQ_KHZ 250000
`define NSP_MCLK_FREQ_KHZ 35328
// master clock half period in reference cycles, rounded up
`define NSP_MCLK_HALF_CYC ((`NSP_REF_FREQ_KHZ + 2 * `NSP_MCLK_FREQ_KHZ - 1) / (2 * `NSP_MCLK_FREQ_KHZ))

// sample word and nibble layout
`define NSP_WORD_BITS 16
`define NSP_NIBBLES 4
`define NSP_RX_VALUE_BITS 18

// serial control frame
`define NSP_CTL_BITS 16
`define NSP_CTL_STOP_BITS 16
`define NSP_CTL_ADDR_LSB 0
`define NSP_ADDR_FORMAT 3'h1
`define NSP_ADDR_CLIP 3'h2
`define NSP_FMT_BIT 9
`define NSP_DIV_LSB 6
`define NSP_CLIP_CLR_BIT 3

// saturation limits
`define NSP_SAT1_HI 16'h7fff
`define NSP_SAT1_LO 16'h8000
`define NSP_SAT2_HI 16'h3fff
`define NSP_SAT2_LO 16'hc000

// reset values
`define NSP_DIV_RST 2'h0
`define NSP_FMT_RST 1'h0

`endif

/* File: nsp_pkg.sv */
/*
 * Types of the nibble sample port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package nsp_pkg;

	// serial control frame receiver states
	typedef enum logic [1:0] {
		NSP_CTL_IDLE,
		NSP_CTL_DATA,
		NSP_CTL_STOP
	} nsp_ctl_state_t;

	// divider code: 0..3 selects 1, 2, 4, 8
	typedef logic [1:0] nsp_div_t;

endpackage : nsp_pkg

/* File: nsp_tim_if.sv */
/*
 * Timing strobes passed from the clock generator to the port logic.
 * Assumes both ends run on ref_clk.
 */
`timescale 1ns/1ns

interface nsp_tim_if;
	import nsp_pkg::*;
	logic rise_evt;
	logic fall_evt;
	logic nib_start;
	logic word_start;
	logic wclk_fall;
	logic tx_sample;
	logic [1:0] nib_idx;
	nsp_div_t div_code;

	modport gen (
		output rise_evt, fall_evt, nib_start, word_start, wclk_fall, tx_sample, nib_idx,
		input div_code
	);
	modport use_side (
		input rise_evt, fall_evt, nib_start, word_start, wclk_fall, tx_sample, nib_idx,
		output div_code
	);
endinterface : nsp_tim_if

/* File: nsp_clk_gen.sv */
/*
 * Master, nibble and word clock generator with the nibble counter.
 * Assumes ref_clk is the only clock; the divider code may change
 * at word clock falls and is latched only at word starts.
 */
`timescale 1ns/1ns
`include "nsp_consts.svh"

module nsp_clk_gen
	import nsp_pkg::*;
#(
	parameter int HALF = `NSP_MCLK_HALF_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// strobes to the port logic
	nsp_tim_if.gen tim,
	// clock pins
	output logic master_clock_out,
	output logic divided_nibble_clock,
	output logic word_clock
);
	localparam int HW = (HALF > 1) ? $clog2(HALF) : 1;

	logic [HW-1:0] half_cnt_reg;
	logic mclk_reg;
	logic nclk_reg;
	logic wclk_reg;
	logic [2:0] ndiv_reg;
	logic [2:0] ndiv_next;
	logic [1:0] idx_reg;
	nsp_div_t wdiv_reg;
	logic [3:0] nper;
	logic [2:0] nmax;
	logic at_half;
	logic [15:0] gap_cnt_reg;
	logic seen_reg;

	// master periods per nibble for this word
	assign nper = 4'h1 << wdiv_reg;
	assign nmax = 3'(nper - 4'h1);
	assign ndiv_next = ndiv_reg + 3'h1;
	assign at_half = half_cnt_reg == HW'(HALF - 1);

	// edge and boundary strobes
	assign tim.rise_evt = at_half && !mclk_reg;
	assign tim.fall_evt = at_half && mclk_reg;
	assign tim.nib_start = tim.rise_evt && (ndiv_reg == nmax);
	assign tim.word_start = tim.nib_start && (idx_reg == 2'h3);
	assign tim.wclk_fall = tim.nib_start && (idx_reg == 2'h0);
	assign tim.tx_sample = tim.fall_evt && (ndiv_reg == 3'h0);
	assign tim.nib_idx = idx_reg;
	assign master_clock_out = mclk_reg;
	assign divided_nibble_clock = nclk_reg;
	assign word_clock = wclk_reg;

	// master clock divider from ref_clk
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			half_cnt_reg <= '0;
			mclk_reg <= 1'h0;
		end else if (at_half) begin
			half_cnt_reg <= '0;
			mclk_reg <= !mclk_reg;
		end else begin
			half_cnt_reg <= half_cnt_reg + HW'(1);
		end
	end

	// nibble position, advanced on master rising edges
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ndiv_reg <= 3'h0;
			idx_reg <= 2'h3;
		end else if (tim.nib_start) begin
			ndiv_reg <= 3'h0;
			idx_reg <= idx_reg + 2'h1;
		end else if (tim.rise_evt) begin
			ndiv_reg <= ndiv_next;
		end
	end

	// divider latched only at word boundaries
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wdiv_reg <= `NSP_DIV_RST;
		end else if (tim.word_start) begin
			wdiv_reg <= tim.div_code;
		end
	end

	// nibble clock high in first half of nibble, word clock in first nibble
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			nclk_reg <= 1'h0;
			wclk_reg <= 1'h0;
		end else begin
			if (tim.nib_start) begin
				nclk_reg <= 1'h1;
				wclk_reg <= idx_reg == 2'h3;
			end else if (tim.rise_evt) begin
				nclk_reg <= {1'h0, ndiv_next} < (nper >> 1);
			end else if (tim.fall_evt && wdiv_reg == 2'h0) begin
				nclk_reg <= 1'h0;
			end
		end
	end

	// helper: reference cycles between word starts
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			gap_cnt_reg <= 16'h0;
			seen_reg <= 1'h0;
		end else if (tim.word_start) begin
			gap_cnt_reg <= 16'h0;
			seen_reg <= 1'h1;
		end else begin
			gap_cnt_reg <= gap_cnt_reg + 16'h1;
		end
	end

	default clocking gen_cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	word_period_a: assert property ((tim.word_start && seen_reg) |->
		gap_cnt_reg == 16'(int'(nper) * 4 * 2 * HALF - 1))
		else $error("word period does not match divider");
	nibble_follow_a: assert property ((wdiv_reg == 2'h0 && !tim.word_start) |=>
		divided_nibble_clock == master_clock_out)
		else $error("nibble clock not equal to master clock at divider one");

endmodule : nsp_clk_gen

/* File: nsp_nibble_port.sv */
/*
 * Nibble-serial sample port of the front end: clocks out to the
 * processor, receive samples saturated and sent as four nibbles,
 * transmit nibbles gathered into words, serial control frames and
 * the sticky clip pin.
 * Assumes all pin inputs are synchronous to ref_clk and that the
 * processor drives transmit nibbles on master rising edges.
 */
// Summary of operation
// - receive lines change on master rising edge
// - word clock high marks first nibble
// - four nibbles, low bits first, line 0 LSB
// - nibble clock is master divided by divider
// - divider 1, 2, 4 or 8 sets rate
// - format bit selects one or two sign bits
// - two-sign transmit: bits 15, 14 carry sign
// - one-sign transmit: bit 14 data, 15 sign
// - two-sign receive: sign on lines 2, 3
// - one-sign receive: bit 14 then sign
// - one-sign receive saturates to 7fff/8000
// - two-sign receive saturates to 3fff/c000
// - clip high until clip-clear zero written while the sent word is unclipped
// - serial control frames, sixteen stop bits commit
// - device drives master, nibble, word clocks
`timescale 1ns/1ns
`include "nsp_consts.svh"

module nsp_nibble_port
	import nsp_pkg::*;
#(
	parameter int RXW = `NSP_RX_VALUE_BITS,
	parameter int MCLK_HALF = `NSP_MCLK_HALF_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// internal receive path
	input wire logic signed [RXW-1:0] internal_receive_value,
	output logic rx_take,
	// internal transmit path
	output logic [15:0] tx_word,
	output logic tx_valid,
	// clock pins to the processor
	output logic master_clock_out,
	output logic divided_nibble_clock,
	output logic word_clock,
	// data pins
	input wire logic [3:0] tx_nibble,
	output logic [3:0] rx_nibble,
	// control and status pins
	input wire logic serial_control_input,
	output logic clip_out,
	// programmed state
	output logic one_sign_fmt,
	output logic [1:0] div_code
);
	nsp_tim_if tim ();

	nsp_ctl_state_t ctl_state_reg;
	logic [15:0] ctl_sh_reg;
	logic [15:0] ctl_sh_next;
	logic [3:0] bit_cnt_reg;
	logic [3:0] stop_cnt_reg;
	logic fmt_one_reg;
	nsp_div_t div_reg;
	logic clip_clr_reg;
	logic [15:0] tx_acc_reg;
	logic [15:0] tx_word_reg;
	logic tx_valid_reg;
	logic [15:0] rx_word_reg;
	logic rx_fmt_word_reg;
	logic [3:0] rx_nib_reg;
	logic [1:0] nib_idx_next;
	logic clip_reg;
	logic [15:0] sat_hi16;
	logic [15:0] sat_lo16;
	logic signed [RXW-1:0] sat_hi;
	logic signed [RXW-1:0] sat_lo;
	logic [15:0] sat_word;
	logic sat_hit;
	logic sat_evt;
	logic rx_sat_reg;

	nsp_clk_gen #(
		.HALF(MCLK_HALF)
	) u_clk_gen (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.tim(tim.gen),
		.master_clock_out(master_clock_out),
		.divided_nibble_clock(divided_nibble_clock),
		.word_clock(word_clock)
	);

	// programmed settings to the clock generator and out
	assign tim.div_code = div_reg;
	assign div_code = div_reg;
	assign one_sign_fmt = fmt_one_reg;

	// pin and path outputs
	assign rx_nibble = rx_nib_reg;
	assign clip_out = clip_reg;
	assign tx_word = tx_word_reg;
	assign tx_valid = tx_valid_reg;
	assign rx_take = tim.word_start;

	// control bits arrive msb first
	assign ctl_sh_next = {ctl_sh_reg[14:0], serial_control_input};

	// serial control frames, sampled on word clock falling edge
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_state_reg <= NSP_CTL_IDLE;
			ctl_sh_reg <= 16'h0;
			bit_cnt_reg <= 4'h0;
			stop_cnt_reg <= 4'h0;
			fmt_one_reg <= `NSP_FMT_RST;
			div_reg <= `NSP_DIV_RST;
			clip_clr_reg <= 1'h0;
		end else begin
			clip_clr_reg <= 1'h0;
			if (tim.wclk_fall) begin
				case (ctl_state_reg)
					NSP_CTL_IDLE: begin
						// a low bit is the frame's first bit
						if (!serial_control_input) begin
							ctl_sh_reg <= ctl_sh_next;
							bit_cnt_reg <= 4'h1;
							ctl_state_reg <= NSP_CTL_DATA;
						end
					end
					NSP_CTL_DATA: begin
						ctl_sh_reg <= ctl_sh_next;
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (bit_cnt_reg == 4'hf) begin
							stop_cnt_reg <= 4'h0;
							ctl_state_reg <= NSP_CTL_STOP;
						end
					end
					NSP_CTL_STOP: begin
						if (serial_control_input) begin
							stop_cnt_reg <= stop_cnt_reg + 4'h1;
							if (stop_cnt_reg == 4'hf) begin
								// sixteenth stop bit: frame takes effect
								ctl_state_reg <= NSP_CTL_IDLE;
								case (ctl_sh_reg[`NSP_CTL_ADDR_LSB +: 3])
									`NSP_ADDR_FORMAT: begin
										fmt_one_reg <= ctl_sh_reg[`NSP_FMT_BIT];
										div_reg <= ctl_sh_reg[`NSP_DIV_LSB +: 2];
									end
									`NSP_ADDR_CLIP: begin
										clip_clr_reg <= !ctl_sh_reg[`NSP_CLIP_CLR_BIT];
									end
									default: begin
									end
								endcase
							end
						end else begin
							// low before enough stop bits: drop frame, start anew
							ctl_sh_reg <= ctl_sh_next;
							bit_cnt_reg <= 4'h1;
							ctl_state_reg <= NSP_CTL_DATA;
						end
					end
					default: begin
						ctl_state_reg <= NSP_CTL_IDLE;
					end
				endcase
			end
		end
	end

	// transmit nibbles, sampled on the master falling edge
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_acc_reg <= 16'h0;
			tx_word_reg <= 16'h0;
			tx_valid_reg <= 1'h0;
		end else begin
			tx_valid_reg <= 1'h0;
			if (tim.tx_sample) begin
				tx_acc_reg[{tim.nib_idx, 2'h0} +: 4] <= tx_nibble;
				if (tim.nib_idx == 2'h3) begin
					// last nibble: lines 2 and 3 are bits 14 and 15 in both formats
					tx_word_reg <= {tx_nibble, tx_acc_reg[11:0]};
					tx_valid_reg <= 1'h1;
				end
			end
		end
	end

	// saturation limits for the selected format
	always_comb begin
		sat_hi16 = fmt_one_reg ? `NSP_SAT1_HI : `NSP_SAT2_HI;
		sat_lo16 = fmt_one_reg ? `NSP_SAT1_LO : `NSP_SAT2_LO;
		sat_hi = {{(RXW - 16){sat_hi16[15]}}, sat_hi16};
		sat_lo = {{(RXW - 16){sat_lo16[15]}}, sat_lo16};
	end

	// clip the internal receive value into the output range
	always_comb begin
		sat_hit = 1'h0;
		sat_word = internal_receive_value[15:0];
		if (internal_receive_value > sat_hi) begin
			sat_hit = 1'h1;
			sat_word = sat_hi16;
		end else if (internal_receive_value < sat_lo) begin
			sat_hit = 1'h1;
			sat_word = sat_lo16;
		end
		if (!fmt_one_reg) begin
			sat_word[14] = sat_word[15];
		end
	end

	assign sat_evt = tim.word_start && sat_hit;
	assign nib_idx_next = tim.nib_idx + 2'h1;

	// receive word loaded at word start, nibbles on master rise
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_word_reg <= 16'h0;
			rx_fmt_word_reg <= `NSP_FMT_RST;
			rx_nib_reg <= 4'h0;
		end else if (tim.word_start) begin
			rx_word_reg <= sat_word;
			rx_fmt_word_reg <= fmt_one_reg;
			rx_nib_reg <= sat_word[3:0];
		end else if (tim.nib_start) begin
			rx_nib_reg <= rx_word_reg[{nib_idx_next, 2'h0} +: 4];
		end
	end

	// word now on the receive lines was clipped: saturation still going on
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_sat_reg <= 1'h0;
		end else if (tim.word_start) begin
			rx_sat_reg <= sat_hit;
		end
	end

	// sticky clip pin, a new clip beats the clear
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			clip_reg <= 1'h0;
		end else if (sat_evt) begin
			clip_reg <= 1'h1;
		end else if (clip_clr_reg && !rx_sat_reg) begin
			// clear refused while the word being sent is a clipped one
			clip_reg <= 1'h0;
		end
	end

	default clocking port_cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	// receive path checks
	rx_on_rise_a: assert property ($changed(rx_nibble) |-> $rose(master_clock_out))
		else $error("receive nibble changed off a master rising edge");
	word_first_nib_a: assert property ($rose(word_clock) |-> rx_nibble == rx_word_reg[3:0])
		else $error("first nibble not low bits at word clock");
	last_nib_a: assert property ((tim.nib_start && tim.nib_idx == 2'h2) |=>
		rx_nibble == rx_word_reg[15:12])
		else $error("last nibble not high bits");
	two_sign_rx_a: assert property ((tim.nib_idx == 2'h3 && !rx_fmt_word_reg) |->
		rx_nibble[3] == rx_nibble[2])
		else $error("two sign bits differ on last nibble");
	one_sign_rx_a: assert property ((tim.nib_idx == 2'h3 && rx_fmt_word_reg) |->
		rx_nibble == rx_word_reg[15:12])
		else $error("one sign last nibble wrong");
	sat_one_a: assert property ((tim.word_start && fmt_one_reg && sat_hit &&
		!internal_receive_value[RXW-1]) |=> rx_word_reg == 16'h7fff)
		else $error("positive clip not at 7fff");
	sat_two_a: assert property ((tim.word_start && !fmt_one_reg) |=>
		(rx_word_reg[15:14] == 2'h0 || rx_word_reg[15:14] == 2'h3))
		else $error("two sign word out of range");
	// clip pin checks, then the transmit word check
	clip_cause_a: assert property ($rose(clip_out) |-> $past(sat_evt))
		else $error("clip rose without saturation");
	clip_hold_a: assert property ((clip_out && !clip_clr_reg) |=> clip_out)
		else $error("clip dropped without clear");
	clip_prio_a: assert property (((sat_evt || rx_sat_reg) && clip_clr_reg) |=> clip_out)
		else $error("clear beat a saturation");
	tx_word_a: assert property ((tim.tx_sample && tim.nib_idx == 2'h3) |=>
		(tx_valid && tx_word[15:12] == $past(tx_nibble)))
		else $error("transmit word not assembled");

	// further limits, clip set, word alignment and settings commit
	sat_neg_a: assert property ((tim.word_start && fmt_one_reg && sat_hit &&
		internal_receive_value[RXW-1]) |=> rx_word_reg == `NSP_SAT1_LO)
		else $error("negative clip not at 8000");
	sat_two_hi_a: assert property ((tim.word_start && !fmt_one_reg && sat_hit &&
		!internal_receive_value[RXW-1]) |=> rx_word_reg == `NSP_SAT2_HI)
		else $error("positive clip not at 3fff");
	clip_set_a: assert property (sat_evt |=> clip_out)
		else $error("clip not raised by a saturation");
	word_align_a: assert property (tim.word_start |=>
		(word_clock && divided_nibble_clock && tim.nib_idx == 2'h0))
		else $error("word start not aligned to nibble zero");
	cfg_commit_a: assert property ((ctl_state_reg != NSP_CTL_STOP || !tim.wclk_fall) |=>
		($stable(div_reg) && $stable(fmt_one_reg)))
		else $error("setting changed outside a frame commit");

endmodule : nsp_nibble_port

/* File: nsp_dsp_model.sv */
/* processor-side partner of the nibble port: sends transmit words,
   gathers receive words, shifts control frames.
   assumes the device clock pins are registered on ref_clk. */
`timescale 1ns/1ns
module nsp_dsp_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// device pins
	input wire logic master_clock_out,
	input wire logic divided_nibble_clock,
	input wire logic word_clock,
	input wire logic [3:0] rx_nibble,
	output logic [3:0] tx_nibble,
	output logic serial_control_input,
	// bench side
	input wire logic [15:0] tx_data,
	input wire logic [15:0] ctl_word,
	input wire logic ctl_go,
	output logic tx_load,
	output logic rx_done,
	output logic [15:0] rx_word,
	output logic ctl_busy,
	output logic rx_glitch
);
	logic m_q, n_q, have_reg;
	logic [1:0] idx_reg, k;
	logic [3:0] rx_q;
	logic [15:0] cur_reg, acc_reg, sh_reg, w;
	logic [5:0] left_reg;
	assign ctl_busy = left_reg != 6'h0;
	// nibble engine, stepped at nibble starts and master falls
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			{m_q, n_q, have_reg, tx_load, rx_done, rx_glitch} <= 6'h0;
			{idx_reg, rx_q, tx_nibble, left_reg} <= 16'h0;
			{cur_reg, acc_reg, sh_reg, rx_word} <= 64'h0;
			serial_control_input <= 1'b1;
		end else begin
			m_q <= master_clock_out;
			n_q <= divided_nibble_clock;
			rx_q <= rx_nibble;
			tx_load <= 1'b0;
			rx_done <= 1'b0;
			// receive lines may only move with a master rise
			if (rx_nibble !== rx_q && !(master_clock_out && !m_q)) rx_glitch <= 1'b1;
			if (divided_nibble_clock && !n_q) begin
				k = word_clock ? 2'h0 : idx_reg + 2'h1;
				w = word_clock ? tx_data : cur_reg;
				tx_nibble <= w[4*k +: 4];
				idx_reg <= k;
				if (word_clock) begin
					cur_reg <= tx_data;
					tx_load <= 1'b1;
					rx_done <= have_reg;
					rx_word <= acc_reg;
					have_reg <= 1'b1;
					if (ctl_busy) begin
						serial_control_input <= sh_reg[15];
						sh_reg <= {sh_reg[14:0], 1'b1};
						left_reg <= left_reg - 6'h1;
					end
				end
			end
			if (!master_clock_out && m_q) acc_reg[4*idx_reg +: 4] <= rx_nibble;
			// 16 frame bits then 17 high stop bits
			if (ctl_go) begin
				sh_reg <= ctl_word;
				left_reg <= 6'h21;
			end
		end
	end
endmodule : nsp_dsp_model

/* File: nsp_nibble_port_tb.sv */
/* self-checking bench of the nibble port against the processor model.
   assumes nsp_pkg and the port's modules are compiled first. */
`timescale 1ns/1ns
module nsp_nibble_port_tb;
	import nsp_pkg::*;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic signed [17:0] rx_val = 18'h0;
	logic [15:0] tx_data = 16'h0;
	logic [15:0] ctl_word = 16'hffff;
	logic ctl_go = 1'b0;
	logic safe = 1'b1;
	logic pin = 1'b0;
	logic clip_drop = 1'b0;
	logic fmt1 = 1'b0;
	logic wq = 1'b0;
	logic nq = 1'b0;
	logic rx_take, tx_valid, master_clock_out, divided_nibble_clock, word_clock;
	logic serial_control_input, clip_out, one_sign_fmt, tx_load, rx_done, ctl_busy, rx_glitch;
	logic [1:0] div_code;
	logic [3:0] tx_nibble, rx_nibble;
	logic [15:0] tx_word, rx_word, d;
	logic [15:0] rx_exp[$];
	logic [15:0] tx_exp[$];
	integer seed = 10083;
	int bad_count = 0;
	int total_checks = 0;

	nsp_nibble_port #(.RXW(18), .MCLK_HALF(4)) dut (
		.ref_clk, .arst_n, .internal_receive_value(rx_val), .rx_take, .tx_word, .tx_valid,
		.master_clock_out, .divided_nibble_clock, .word_clock, .tx_nibble, .rx_nibble,
		.serial_control_input, .clip_out, .one_sign_fmt, .div_code
	);
	nsp_dsp_model proc (
		.ref_clk, .arst_n, .master_clock_out, .divided_nibble_clock, .word_clock, .rx_nibble,
		.tx_nibble, .serial_control_input, .tx_data, .ctl_word, .ctl_go, .tx_load, .rx_done,
		.rx_word, .ctl_busy, .rx_glitch
	);

	// 250 mhz reference clock
	always #2 ref_clk = ~ref_clk;

	// saturation as the receive path must apply it
	function automatic logic [15:0] sat(input logic signed [17:0] v, input logic one);
		if (one) return v > 18'sh07fff ? 16'h7fff : v < 18'sh38000 ? 16'h8000 : v[15:0];
		return v > 18'sh03fff ? 16'h3fff : v < 18'sh3c000 ? 16'hc000 : v[15:0];
	endfunction : sat

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude

	task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : check16

	task automatic checkn(input string what, input int exp, input int got);
		total_checks++;
		if (got != exp) begin
			bad_count++;
			$display("unexpected %s expected %0d seen %0d", what, exp, got);
		end
	endtask : checkn

	// drivers note expectations, then draw fresh random values
	always @(posedge ref_clk) begin
		wq <= word_clock;
		nq <= divided_nibble_clock;
		if (rx_take === 1'b1) begin
			rx_exp.push_back(sat(rx_val, fmt1));
			rx_val <= pin ? 18'h1ffff : safe ? 18'($random(seed) % 16384) : 18'($random(seed));
		end
		if (tx_load === 1'b1) begin
			tx_exp.push_back(tx_data);
			d = 16'($random(seed));
			tx_data <= fmt1 ? d : {d[14], d[14:0]};
		end
	end

	// monitor takes the oldest note per result
	always @(posedge ref_clk) begin
		if (rx_done === 1'b1 && rx_exp.size() > 0)
			check16("receive word", rx_exp.pop_front(), rx_word);
		if (tx_valid === 1'b1 && tx_exp.size() > 0)
			check16("transmit word", tx_exp.pop_front(), tx_word);
		if (pin === 1'b1 && clip_out !== 1'b1) clip_drop <= 1'b1;
	end

	task automatic wait_words(input int n);
		int g;
		for (int i = 0; i < n; i++) begin
			g = 0;
			do begin
				@(posedge ref_clk);
				g++;
			end while (!(word_clock === 1'b1 && wq === 1'b0) && g < 600);
			if (g >= 600) begin
				bad_count++;
				conclude();
			end
		end
	endtask : wait_words

	task automatic ctl_write(input logic [15:0] v);
		int g;
		@(posedge ref_clk);
		ctl_word <= v;
		ctl_go <= 1'b1;
		@(posedge ref_clk);
		ctl_go <= 1'b0;
		g = 0;
		do begin
			@(posedge ref_clk);
			g++;
		end while (ctl_busy !== 1'b0 && g < 20000);
		if (g >= 20000) begin
			bad_count++;
			conclude();
		end
	endtask : ctl_write

	// one word period: length, nibble starts, word clock high time
	task automatic measure(input int c);
		int cyc, nib, hi;
		wait_words(2);
		cyc = 0;
		nib = 0;
		hi = 0;
		do begin
			@(posedge ref_clk);
			cyc++;
			nib += (divided_nibble_clock === 1'b1 && nq === 1'b0);
			hi += (word_clock === 1'b1);
		end while (!(word_clock === 1'b1 && wq === 1'b0) && cyc < 600);
		checkn("word period", 32 << c, cyc);
		checkn("nibbles per word", 4, nib);
		checkn("word clock high", 8 << c, hi);
		check16("divider code", 16'(c), {14'h0, div_code});
	endtask : measure

	// saturating burst, a clear under steady clipping, then a clear with quiet samples
	task automatic storm();
		wait_words(2);
		safe <= 1'b0;
		wait_words(20);
		pin <= 1'b1;
		wait_words(3);
		check16("clip set", 16'h1, {15'h0, clip_out});
		ctl_write(16'h0002);
		check16("clip held", 16'h0, {15'h0, clip_drop});
		pin <= 1'b0;
		safe <= 1'b1;
		wait_words(3);
		ctl_write(16'h0002);
		check16("clip cleared", 16'h0, {15'h0, clip_out});
	endtask : storm

	// main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			ctl_write(16'h0001 | 16'(c << 6));
			measure(c);
		end
		ctl_write(16'h0003);
		measure(3);
		ctl_write(16'h0201);
		fmt1 <= 1'b1;
		check16("format flag", 16'h1, {15'h0, one_sign_fmt});
		storm();
		ctl_write(16'h0001);
		fmt1 <= 1'b0;
		storm();
		check16("receive line timing", 16'h0, {15'h0, rx_glitch});
		conclude();
	end
endmodule : nsp_nibble_port_tb
